// file: rtl/line_buffer_cfg.svh
// Constants of the serial line delay buffer: depths, limits, widths.
// Assumes inclusion by the package and the design file, in any order.
`ifndef LINE_BUFFER_CFG_SVH
`define LINE_BUFFER_CFG_SVH

`define LB_ADDR_W      13
`define LB_DATA_W      8
`define LB_ADDR_ZERO   13'h0000
`define LB_ADDR_ONE    13'h0001
`define LB_ADDR_LAST   13'h13b7
`define LB_FAST_WORDS  8
`define LB_FAST_LIMIT  13'h0008
`define LB_FAST_MSB    2
`define LB_BULK_WORDS  5040
`define LB_FIFO_DEPTH  32

`endif

// file: rtl/line_buffer_pkg.sv
// Types shared by the serial line delay buffer and its testbench.
// Assumes line_buffer_cfg.svh is on the include path.
`include "line_buffer_cfg.svh"

package line_buffer_pkg;

   typedef logic [`LB_ADDR_W-1:0] addr_t;
   typedef logic [`LB_DATA_W-1:0] byte_t;

   // Write-side pins, sampled on clk
   typedef struct packed {
      logic  clock;
      logic  enable_n;
      logic  clear_n;
      byte_t data;
   } in_pins_t;

   // Read-side control pins, sampled on clk
   typedef struct packed {
      logic clock;
      logic enable_n;
      logic clear_n;
   } out_ctrl_t;

   // One staged write: where and what
   typedef struct packed {
      addr_t addr;
      byte_t data;
   } wr_entry_t;

endpackage : line_buffer_pkg

// file: rtl/serial_line_delay_buffer.sv
// Serial access line buffer of 5048 bytes with a staging FIFO on writes.
// Assumes both port clocks are slow levels sampled on clk, synchronous.
//
// Behaviour
// - Byte captured at write-clock rising edge, stored at write pointer.
// - Byte at read pointer appears on out_byte after read-clock rise.
// - Low clear input at its clock edge returns pointer to address 0.
// - Clear held over several cycles keeps the pointer at address 0.
// - Pointer goes from 0 to 1 only in first cycle clear is high.
// - Held write clear leaves the last captured byte at location 0.
// - Held read clear keeps presenting location 0 every read cycle.
// - After clear release pointer increments once per enabled cycle.
// - Pointer wraps from 5047 to 0, depth 5048 per port.
// - Enable input high freezes that port's pointer, ignores clocks.
// - Common clock and joint clear give exactly 5048-cycle delay.
// - Byte at 0 at write clear is read at next read clear.
// - Periodic joint clears make delay equal to the clear interval.
// - Storage is an 8-byte fast part plus a 5040-byte bulk part.
// - Write and read ports run independently at unrelated rates.
// - Read enable high sets out_byte_oe_n high; out_byte itself stays driven.
// - Enables are sampled once per cycle at their clock's rising edge.
`timescale 1ns/1ps
`include "line_buffer_cfg.svh"

// ****************************************************************
// Staging FIFO
// ****************************************************************
module stage_fifo #(
   parameter int WIDTH = 21,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             push_valid,
   input  wire logic [WIDTH-1:0] push_data,
   output logic                  push_ready,
   output logic                  pop_valid,
   output logic      [WIDTH-1:0] pop_data,
   input  wire logic             pop_ready
);
   // Depth must be a power of two; pointers carry one wrap bit
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] slots [DEPTH];
   logic [PW:0]      wp_q;
   logic [PW:0]      wp_d;
   logic [PW:0]      rp_q;
   logic [PW:0]      rp_d;
   logic             ready_q;
   logic             ready_d;
   logic             push;
   logic             pop;

   // Next pointers; ready is taken from the next fill level
   always_comb begin
      push    = push_valid & ready_q;
      pop     = pop_valid & pop_ready;
      wp_d    = wp_q + {{PW{1'b0}}, push};
      rp_d    = rp_q + {{PW{1'b0}}, pop};
      ready_d = (wp_d - rp_d) != (PW+1)'(DEPTH);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wp_q    <= '0;
         rp_q    <= '0;
         ready_q <= 1'b1;
      end else begin
         wp_q    <= wp_d;
         rp_q    <= rp_d;
         ready_q <= ready_d;
      end
   end

   // Slot storage has no reset; contents are unknown until written
   always_ff @(posedge clk) begin
      if (push) begin
         slots[wp_q[PW-1:0]] <= push_data;
      end
   end

   assign push_ready = ready_q;
   assign pop_valid  = wp_q != rp_q;
   assign pop_data   = slots[rp_q[PW-1:0]];

   // Full FIFO must never take a word
   a_fifo_no_over: assert property (@(posedge clk) disable iff (!rstn)
      (wp_q - rp_q) == (PW+1)'(DEPTH) |-> !push_ready)
      else $error("fifo takes a word while full");

endmodule : stage_fifo

// ****************************************************************
// Line buffer top
// ****************************************************************
module serial_line_delay_buffer (
   input  wire logic                       clk,
   input  wire logic                       rstn,
   input  wire line_buffer_pkg::in_pins_t  in_pins,
   output logic                            in_side_ready,
   input  wire line_buffer_pkg::out_ctrl_t out_ctrl,
   output line_buffer_pkg::byte_t          out_byte,
   output logic                            out_byte_oe_n
);
   import line_buffer_pkg::*;

   // Address helpers shared by both ports
   function automatic logic is_fast(input addr_t a);
      return a < `LB_FAST_LIMIT;
   endfunction : is_fast

   function automatic addr_t bulk_index(input addr_t a);
      return addr_t'(a - `LB_FAST_LIMIT);
   endfunction : bulk_index

   function automatic addr_t next_addr(input addr_t a);
      return (a == `LB_ADDR_LAST) ? `LB_ADDR_ZERO
                                  : addr_t'(a + `LB_ADDR_ONE);
   endfunction : next_addr

   // ****************************************************************
   // Storage
   // ****************************************************************
   byte_t     fast_mem [`LB_FAST_WORDS];
   byte_t     bulk_mem [`LB_BULK_WORDS];

   logic      in_prev_q;
   logic      in_prev_d;
   logic      out_prev_q;
   logic      out_prev_d;
   addr_t     wr_ptr_q;
   addr_t     wr_ptr_d;
   addr_t     rd_ptr_q;
   addr_t     rd_ptr_d;
   byte_t     out_byte_q;
   byte_t     out_byte_d;
   logic      oe_n_q;
   logic      oe_n_d;

   logic      in_edge;
   logic      wr_try;
   logic      wr_go;
   addr_t     wr_addr;
   wr_entry_t push_entry;
   logic      fifo_ready;
   logic      pop_valid;
   logic      pop_ready;
   wr_entry_t pop_entry;
   logic      pop_go;
   logic      out_edge;
   logic      rd_go;
   addr_t     rd_addr;
   byte_t     rd_data;
   logic      bulk_busy;

   // ****************************************************************
   // Write port
   // ****************************************************************
   // Edge of the write clock pin, seen on clk
   always_comb begin
      in_prev_d = in_pins.clock;
      in_edge   = in_pins.clock & ~in_prev_q;
      // Enable sampled only at the write-clock edge
      wr_try    = in_edge & ~in_pins.enable_n;
      // A full FIFO refuses the cycle: pointer stays put
      wr_go     = wr_try & fifo_ready;
      // Clear forces address 0 for this cycle
      wr_addr   = in_pins.clear_n ? wr_ptr_q : `LB_ADDR_ZERO;
      push_entry.addr = wr_addr;
      push_entry.data = in_pins.data;
      wr_ptr_d  = wr_ptr_q;
      if (wr_go) begin
         // Repeated clears keep writing 0, then 1 follows
         wr_ptr_d = next_addr(wr_addr);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         in_prev_q <= 1'b0;
         wr_ptr_q  <= `LB_ADDR_ZERO;
      end else begin
         in_prev_q <= in_prev_d;
         wr_ptr_q  <= wr_ptr_d;
      end
   end

   // Writes are staged so a bulk write can wait behind a bulk read
   stage_fifo #(
      .WIDTH ($bits(wr_entry_t)),
      .DEPTH (`LB_FIFO_DEPTH)
   ) u_stage (
      .clk        (clk),
      .rstn       (rstn),
      .push_valid (wr_try),
      .push_data  (push_entry),
      .push_ready (fifo_ready),
      .pop_valid  (pop_valid),
      .pop_data   (pop_entry),
      .pop_ready  (pop_ready)
   );

   // ****************************************************************
   // Storage arbitration
   // ****************************************************************
   // Fast part never stalls; bulk part is single-ported, read wins
   always_comb begin
      bulk_busy = rd_go & ~is_fast(rd_addr);
      pop_ready = is_fast(pop_entry.addr) | ~bulk_busy;
      pop_go    = pop_valid & pop_ready;
   end

   // Later entries for address 0 overwrite earlier ones in order
   always_ff @(posedge clk) begin
      if (pop_go && is_fast(pop_entry.addr)) begin
         fast_mem[pop_entry.addr[`LB_FAST_MSB:0]] <= pop_entry.data;
      end
      if (pop_go && !is_fast(pop_entry.addr)) begin
         bulk_mem[bulk_index(pop_entry.addr)] <= pop_entry.data;
      end
   end

   // ****************************************************************
   // Read port
   // ****************************************************************
   always_comb begin
      out_prev_d = out_ctrl.clock;
      out_edge   = out_ctrl.clock & ~out_prev_q;
      rd_go      = out_edge & ~out_ctrl.enable_n;
      rd_addr    = out_ctrl.clear_n ? rd_ptr_q : `LB_ADDR_ZERO;
      rd_data    = is_fast(rd_addr) ?
                   fast_mem[rd_addr[`LB_FAST_MSB:0]] :
                   bulk_mem[bulk_index(rd_addr)];
      rd_ptr_d   = rd_ptr_q;
      out_byte_d = out_byte_q;
      oe_n_d     = oe_n_q;
      if (out_edge) begin
         oe_n_d = out_ctrl.enable_n;
      end
      if (rd_go) begin
         out_byte_d = rd_data;
         rd_ptr_d   = next_addr(rd_addr);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_prev_q <= 1'b0;
         rd_ptr_q   <= `LB_ADDR_ZERO;
         out_byte_q <= '0;
         oe_n_q     <= 1'b1;
      end else begin
         out_prev_q <= out_prev_d;
         rd_ptr_q   <= rd_ptr_d;
         out_byte_q <= out_byte_d;
         oe_n_q     <= oe_n_d;
      end
   end

   assign out_byte      = out_byte_q;
   assign out_byte_oe_n = oe_n_q;
   assign in_side_ready = fifo_ready;

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_wr_clear_zero: assert property (@(posedge clk) disable iff (!rstn)
      wr_go && !in_pins.clear_n |-> push_entry.addr == `LB_ADDR_ZERO
      ##1 wr_ptr_q == `LB_ADDR_ONE)
      else $error("write clear did not use address 0");

   a_rd_clear_hold: assert property (@(posedge clk) disable iff (!rstn)
      rd_go && !out_ctrl.clear_n |=> rd_ptr_q == `LB_ADDR_ONE)
      else $error("read clear did not restart at address 1");

   a_wr_step_one: assert property (@(posedge clk) disable iff (!rstn)
      wr_go && in_pins.clear_n && wr_ptr_q != `LB_ADDR_LAST
      |=> wr_ptr_q == addr_t'($past(wr_ptr_q) + `LB_ADDR_ONE))
      else $error("write pointer did not step by one");

   a_rd_wrap_zero: assert property (@(posedge clk) disable iff (!rstn)
      rd_go && out_ctrl.clear_n && rd_ptr_q == `LB_ADDR_LAST
      |=> rd_ptr_q == `LB_ADDR_ZERO)
      else $error("read pointer did not wrap after last address");

   a_wr_freeze_off: assert property (@(posedge clk) disable iff (!rstn)
      !wr_go |=> $stable(wr_ptr_q))
      else $error("write pointer moved without an accepted cycle");

   a_rd_freeze_off: assert property (@(posedge clk) disable iff (!rstn)
      !rd_go |=> $stable(rd_ptr_q) && out_byte_q === $past(out_byte_q))
      else $error("read port moved without an enabled cycle");

   a_out_hiz_off: assert property (@(posedge clk) disable iff (!rstn)
      out_edge && out_ctrl.enable_n |=> out_byte_oe_n ##1
      (out_byte_oe_n throughout !out_edge [*2]) or out_edge)
      else $error("out_byte driven while read disabled");

   a_rd_zero_data: assert property (@(posedge clk) disable iff (!rstn)
      rd_go && !out_ctrl.clear_n |=> out_byte_q === $past(fast_mem[0]))
      else $error("held read clear did not present location 0");

   a_wr_no_store: assert property (@(posedge clk) disable iff (!rstn)
      in_edge && in_pins.enable_n |=> $stable(wr_ptr_q))
      else $error("disabled write cycle advanced the pointer");

   // Read pointer steps by one outside a clear
   a_rd_step_one: assert property (@(posedge clk) disable iff (!rstn)
      rd_go && out_ctrl.clear_n && rd_ptr_q != `LB_ADDR_LAST
      |=> rd_ptr_q == addr_t'($past(rd_ptr_q) + `LB_ADDR_ONE))
      else $error("read pointer did not step by one");

   // Write pointer runs from the last address back to 0
   a_wr_wrap_zero: assert property (@(posedge clk) disable iff (!rstn)
      wr_go && in_pins.clear_n && wr_ptr_q == `LB_ADDR_LAST
      |=> wr_ptr_q == `LB_ADDR_ZERO)
      else $error("write pointer did not wrap after last address");

   // An enabled read always drives the output pins
   a_oe_on_read: assert property (@(posedge clk) disable iff (!rstn)
      rd_go |=> !out_byte_oe_n)
      else $error("out_byte not driven after an enabled read");

   // Enable is latched only at read-clock rises, so oe holds between
   a_oe_hold_edge: assert property (@(posedge clk) disable iff (!rstn)
      !out_edge |=> out_byte_oe_n == $past(out_byte_oe_n))
      else $error("output enable changed between read-clock rises");

   // A staged byte waits at most one cycle behind a bulk read
   a_stage_drains: assert property (@(posedge clk) disable iff (!rstn)
      pop_valid |-> ##[0:1] pop_go)
      else $error("staged write held back more than one cycle");

   // A byte bound for address 0 is in place one cycle later
   a_zero_lands: assert property (@(posedge clk) disable iff (!rstn)
      pop_go && pop_entry.addr == `LB_ADDR_ZERO
      |=> fast_mem[0] == $past(pop_entry.data))
      else $error("byte for address 0 did not land");

endmodule : serial_line_delay_buffer

// file: tb/line_source.sv
// Model of the image logic that drives both pin ports of the line buffer.
// Assumes pins are sampled on clk; this model moves them at falling edges.
`timescale 1ns/1ps

module line_source (
   input  wire logic                  clk,
   output line_buffer_pkg::in_pins_t  in_pins,
   output line_buffer_pkg::out_ctrl_t out_ctrl
);
   import line_buffer_pkg::*;

   // ******************************************************************
   // Pin driver
   // ******************************************************************
   // Pins idle low until the first cycle
   initial begin
      in_pins  = '0;
      out_ctrl = '0;
   end

   // One pin cycle: clock low 2 clk, high 3 clk; a skipped port keeps
   // its clock low, which is how the two rates are made unrelated
   task automatic cycle(input logic wgo, input logic wen_n,
                        input logic wclr_n, input byte_t wd,
                        input logic rgo, input logic ren_n,
                        input logic rclr_n);
      @(negedge clk);
      // Held across the rise; idle data is inverted, never left stale
      in_pins  <= '{1'b0, wen_n, wclr_n, wen_n ? ~wd : wd};
      out_ctrl <= '{1'b0, ren_n, rclr_n};
      repeat (2) @(negedge clk);
      in_pins.clock  <= wgo;
      out_ctrl.clock <= rgo;
      repeat (2) @(negedge clk);
   endtask : cycle
endmodule : line_source

// file: tb/tb_top.sv
// Self-checking bench of the serial line delay buffer against a model.
// Assumes line_source drives the pins; pin cycle is 5 clk long.
`timescale 1ns/1ps

module tb_top;
   import line_buffer_pkg::*;

   // ******************************************************************
   // Bench state
   // ******************************************************************
   localparam int DEPTH = 5048;
   logic        clk;
   logic        rstn;
   in_pins_t    in_pins;
   out_ctrl_t   out_ctrl;
   byte_t       out_byte;
   logic        oe_n;
   logic        rdy;
   logic [31:0] r;
   int          fails;
   int          tests_run;
   byte_t       mem [DEPTH];
   bit          known [DEPTH];
   int          wptr;
   int          rptr;
   byte_t       exp_out;
   logic        exp_oe = 1'b1;
   bit          exp_known;

   serial_line_delay_buffer uut (.clk(clk), .rstn(rstn),
      .in_pins(in_pins), .in_side_ready(rdy), .out_ctrl(out_ctrl),
      .out_byte(out_byte), .out_byte_oe_n(oe_n));
   line_source u_src (.clk(clk), .in_pins(in_pins), .out_ctrl(out_ctrl));

   // 10 MHz system clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // One pin cycle; the model reads before it writes, so a shared
   // address gives back the old byte, as the real part does
   task automatic step(input logic wgo, input logic wen_n,
                       input logic wclr_n, input byte_t wd,
                       input logic rgo, input logic ren_n,
                       input logic rclr_n);
      int ra;
      int wa;
      check("in_side_ready", {7'h0, rdy}, 8'h01);
      u_src.cycle(wgo, wen_n, wclr_n, wd, rgo, ren_n, rclr_n);
      if (rgo) begin
         exp_oe = ren_n;
         if (!ren_n) begin
            ra = rclr_n ? rptr : 0;
            exp_out = mem[ra];
            exp_known = known[ra];
            rptr = (ra + 1) % DEPTH;
         end
      end
      if (wgo && !wen_n) begin
         wa = wclr_n ? wptr : 0;
         mem[wa] = wd;
         known[wa] = 1'b1;
         wptr = (wa + 1) % DEPTH;
      end
      check("out_byte_oe_n", {7'h0, oe_n}, {7'h0, exp_oe});
      if (exp_known && !exp_oe) begin
         check("out_byte", out_byte, exp_out);
      end
   endtask : step

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   // Watchdog well beyond the 30k clk the tests need
   initial begin
      #6_000_000;
      fails++;
      $display("watchdog expired");
      final_report();
   end

   // ******************************************************************
   // Tests
   // ******************************************************************
   initial begin
      rstn = 1'b0;
      void'($urandom(32'h66ca));
      repeat (5) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      // Joint clear, then a full turn plus margin on a common clock
      step(1'b1, 1'b0, 1'b0, byte_t'($urandom), 1'b1, 1'b0, 1'b0);
      for (int i = 0; i < DEPTH + 20; i++) begin
         step(1'b1, 1'b0, 1'b1, byte_t'($urandom), 1'b1, 1'b0,
              1'b1);
      end
      $display("test delay line done");
      // Held clears: last byte stays at 0, read repeats location 0
      for (int i = 0; i < 3; i++) begin
         step(1'b1, 1'b0, 1'b0, byte_t'($urandom), 1'b1, 1'b0,
              1'b0);
      end
      step(1'b1, 1'b0, 1'b1, byte_t'($urandom), 1'b1, 1'b0, 1'b1);
      for (int i = 0; i < 3; i++) begin
         step(1'b1, 1'b1, 1'b1, byte_t'($urandom), 1'b1, 1'b0,
              1'b0);
      end
      $display("test held clear done");
      // Clear offset of 20 cycles sets the delay
      for (int i = 0; i < 60; i++) begin
         step(1'b1, 1'b0, i != 0, byte_t'($urandom), i >= 20, 1'b0,
              i != 20);
      end
      $display("test clear offset done");
      // Joint clears every 100 cycles give a 100 cycle delay
      for (int i = 0; i < 300; i++) begin
         step(1'b1, 1'b0, i % 100 != 0, byte_t'($urandom), 1'b1, 1'b0,
              i % 100 != 0);
      end
      $display("test clear interval done");
      // Random rates, enables and clears on both ports
      for (int i = 0; i < 400; i++) begin
         r = $urandom;
         step(r[0], r[1] & r[2], |r[6:3], r[23:16], r[7], r[8] & r[9],
              |r[13:10]);
      end
      $display("test random traffic done");
      final_report();
   end
endmodule : tb_top
